// [spindle_pkg.sv]
// Purpose: Shared constants for the spindle commutation control block
// Assumes: Register words are 12 bits wide, written by a serial port front end
// Notes: Register indices are those of the serial register map
package spindle_pkg;
	localparam int unsigned  reg_width          = 12;
	localparam logic [3:0]   reg_ctrl_index     = 4'h0;
	localparam logic [3:0]   reg_timing_index   = 4'h1;
	localparam logic [3:0]   reg_blank_index    = 4'h2;
	localparam logic [3:0]   reg_temp_index     = 4'h4;
	localparam logic [3:0]   reg_speed_hi_index = 4'h5;
	localparam logic [3:0]   reg_speed_lo_index = 4'h6;
	localparam logic [3:0]   reg_dac_low_index  = 4'h7;
	localparam logic [3:0]   reg_dac_high_index = 4'h8;
	localparam logic [3:0]   reg_shock_index    = 4'h9;
	// Field positions
	localparam int unsigned  presc_lsb          = 7;
	localparam int unsigned  bias_bit           = 6;
	localparam int unsigned  run_bit            = 5;
	localparam int unsigned  monitor_sel_bit    = 7;
	localparam int unsigned  route_bit          = 6;
	localparam int unsigned  temp_sel_bit       = 0;
	localparam int unsigned  shock_bit          = 10;
	// Forced low bits of the interval counters
	localparam int unsigned  blank_forced       = 3;
	localparam int unsigned  watchdog_forced    = 9;
	localparam int unsigned  startup_forced     = 14;
	localparam int unsigned  limit_forced       = 8;
	localparam int unsigned  timer_width        = 18;
	// Reset values
	localparam logic [11:0]  ctrl_reset         = 12'h000;
	localparam logic [11:0]  timing_reset       = 12'hfff;
	localparam logic [11:0]  blank_reset        = 12'h080;
	localparam logic [11:0]  temp_reset         = 12'h07c;
	localparam logic [11:0]  word_reset         = 12'h000;
	localparam logic [2:0]   state_brake        = 3'h6;
	typedef enum logic [2:0] {
		phase_off_type_idle   = 3'b000,
		phase_first_mask_interval          = 3'b001,
		phase_watch           = 3'b010,
		phase_second_mask_interval          = 3'b011,
		phase_wait_zc         = 3'b100,
		phase_delay           = 3'b101
	} phase_type;
endpackage

// [tick_divider.sv]
// Purpose: Prescaler producing a one-cycle commutation tick enable
// Assumes: Divide code 0..3 selects divide by 4, 8, 16 or 32
// Notes: Changing the code mid-count takes effect at once, since the count is compared with the new end value in the same cycle
`timescale 1ns/1ps
module tick_divider (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [1:0] tick_divide_sel,
	output logic            commutation_tick
);
	logic [4:0] count_q;
	logic [4:0] count_d;
	logic [4:0] last;

	always_comb begin
		last    = 5'((5'h04 << tick_divide_sel) - 5'h01);
		count_d = (count_q >= last) ? 5'h00 : 5'(count_q + 5'h01);
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			count_q <= 5'h00;
		end else begin
			count_q <= count_d;
		end
	end

	assign commutation_tick = (count_q >= last);
endmodule

// [spindle_commutation_control.sv]
// Purpose: Sensorless spindle commutation logic and write-only register fields
// Assumes: A serial front end presents one 12-bit word with its index and a write strobe
// Notes: Phase outputs are a drive level and an enable per phase; enable low is float
`timescale 1ns/1ps
module spindle_commutation_control #(
	parameter int unsigned tw = spindle_pkg::timer_width
) (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [3:0]  reg_index,
	input  wire logic [11:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        backemf_comparator_in,
	output logic [2:0]       phase_high,
	output logic [2:0]       phase_drive_en,
	output logic [2:0]       commutation_state,
	output logic             commutation_monitor_pin,
	output logic             centre_tap_bias_en,
	output logic [14:0]      speed_divisor,
	output logic [1:0]       phase_loop_pump_current,
	output logic             small_dac_route_sel,
	output logic [5:0]       small_dac_to_actuator,
	output logic [5:0]       small_dac_to_spindle,
	output logic [11:0]      actuator_word,
	output logic             actuator_high_gain,
	output logic             temp_pin_function_sel,
	output logic [2:0]       shock_threshold,
	output logic [11:0]      temp_sleep_bits
);
	// Counters must hold the widest load, the start-up value
	if (tw < spindle_pkg::startup_forced + 4) begin : g_tw_check
		$error("timer width too small for the start-up load");
	end

	logic [11:0] ctrl_q, timing_q, blank_q, temp_q, speed_hi_q, speed_lo_q, act_q, shock_q;
	logic [11:0] ctrl_d, timing_d, blank_d, temp_d, speed_hi_d, speed_lo_d, act_d, shock_d;
	logic        gain_q, gain_d;

	always_comb begin
		ctrl_d     = ctrl_q;
		timing_d   = timing_q;
		blank_d    = blank_q;
		temp_d     = temp_q;
		speed_hi_d = speed_hi_q;
		speed_lo_d = speed_lo_q;
		act_d      = act_q;
		gain_d     = gain_q;
		shock_d    = shock_q;
		if (reg_write) begin
			case (reg_index)
				spindle_pkg::reg_ctrl_index:     ctrl_d     = reg_wdata;
				spindle_pkg::reg_timing_index:   timing_d   = reg_wdata;
				spindle_pkg::reg_blank_index:    blank_d    = reg_wdata;
				spindle_pkg::reg_temp_index:     temp_d     = reg_wdata;
				spindle_pkg::reg_speed_hi_index: speed_hi_d = reg_wdata;
				spindle_pkg::reg_speed_lo_index: speed_lo_d = reg_wdata;
				spindle_pkg::reg_dac_low_index: begin
					act_d  = reg_wdata;
					gain_d = 1'b0;
				end
				spindle_pkg::reg_dac_high_index: begin
					act_d  = reg_wdata;
					gain_d = 1'b1;
				end
				spindle_pkg::reg_shock_index:    shock_d    = reg_wdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_q     <= spindle_pkg::ctrl_reset;
			timing_q   <= spindle_pkg::timing_reset;
			blank_q    <= spindle_pkg::blank_reset;
			temp_q     <= spindle_pkg::temp_reset;
			speed_hi_q <= spindle_pkg::word_reset;
			speed_lo_q <= spindle_pkg::word_reset;
			act_q      <= spindle_pkg::word_reset;
			gain_q     <= 1'b0;
			shock_q    <= spindle_pkg::word_reset;
		end else begin
			ctrl_q     <= ctrl_d;
			timing_q   <= timing_d;
			blank_q    <= blank_d;
			temp_q     <= temp_d;
			speed_hi_q <= speed_hi_d;
			speed_lo_q <= speed_lo_d;
			act_q      <= act_d;
			gain_q     <= gain_d;
			shock_q    <= shock_d;
		end
	end

	logic tick;
	tick_divider u_div (
		.mclk             (mclk),
		.reset            (reset),
		.tick_divide_sel  (ctrl_q[spindle_pkg::presc_lsb +: 2]),
		.commutation_tick (tick)
	);

	// Comparator synchroniser on the tick rate
	logic sync1_q, sync2_q, sync3_q, sync1_d, sync2_d, sync3_d;
	always_comb begin
		sync1_d = tick ? backemf_comparator_in : sync1_q;
		sync2_d = tick ? sync1_q : sync2_q;
		sync3_d = tick ? sync2_q : sync3_q;
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			sync3_q <= sync3_d;
		end
	end
	logic crossing;
	assign crossing = tick && (sync2_q != sync3_q);

	// Commutation sequencer
	spindle_pkg::phase_type phase_q, phase_d;
	logic [tw-1:0] down_q, down_d, meas_q, meas_d, delay_q, delay_d;
	logic [2:0]    state_q, state_d;
	logic          mon_q, mon_d, measured_q, measured_d;
	logic          run;
	logic [tw-1:0] blank_load, watch_load, start_load, limit_val, half_meas;

	assign run = ctrl_q[spindle_pkg::run_bit];

	always_comb begin
		blank_load = tw'({blank_q[11:8], {spindle_pkg::blank_forced{1'b1}}});
		watch_load = tw'({timing_q[3:0], {spindle_pkg::watchdog_forced{1'b1}}});
		start_load = tw'({timing_q[11:8], {spindle_pkg::startup_forced{1'b1}}});
		limit_val  = tw'({timing_q[7:4], {spindle_pkg::limit_forced{1'b1}}});
		half_meas  = (meas_q < limit_val) ? (meas_q >> 1) : (limit_val >> 1);
	end

	always_comb begin
		phase_d    = phase_q;
		down_d     = down_q;
		meas_d     = meas_q;
		delay_d    = delay_q;
		state_d    = state_q;
		mon_d      = mon_q;
		measured_d = measured_q;
		if (!run) begin
			phase_d    = spindle_pkg::phase_off_type_idle;
			state_d    = 3'h0;
			measured_d = 1'b0;
			mon_d      = 1'b1;
			meas_d     = '0;
		end else if (tick) begin
			if (meas_q < limit_val) begin
				meas_d = tw'(meas_q + 1'b1);
			end
			if (down_q != '0) begin
				down_d = tw'(down_q - 1'b1);
			end
			case (phase_q)
				spindle_pkg::phase_off_type_idle: begin
					phase_d = spindle_pkg::phase_first_mask_interval;
					down_d  = blank_load;
				end
				spindle_pkg::phase_first_mask_interval: begin
					mon_d = 1'b1;
					if (down_q == '0) begin
						phase_d = spindle_pkg::phase_watch;
						down_d  = watch_load;
					end
				end
				spindle_pkg::phase_watch: begin
					if (crossing) begin
						phase_d = spindle_pkg::phase_second_mask_interval;
						down_d  = blank_load;
					end else if (down_q == '0) begin
						state_d = (state_q == 3'h5) ? 3'h0 : 3'(state_q + 3'h1);
						phase_d = spindle_pkg::phase_first_mask_interval;
						down_d  = blank_load;
					end
				end
				spindle_pkg::phase_second_mask_interval: begin
					if (down_q == '0) begin
						phase_d = spindle_pkg::phase_wait_zc;
						down_d  = start_load;
					end
				end
				spindle_pkg::phase_wait_zc: begin
					if (crossing) begin
						mon_d      = 1'b0;
						meas_d     = '0;
						measured_d = 1'b1;
						delay_d    = measured_q ? half_meas : (limit_val >> 1);
						phase_d    = spindle_pkg::phase_delay;
					end else if (down_q == '0) begin
						state_d = (state_q == 3'h5) ? 3'h0 : 3'(state_q + 3'h1);
						phase_d = spindle_pkg::phase_first_mask_interval;
						down_d  = blank_load;
					end
				end
				spindle_pkg::phase_delay: begin
					if (delay_q == '0) begin
						state_d = (state_q == 3'h5) ? 3'h0 : 3'(state_q + 3'h1);
						phase_d = spindle_pkg::phase_first_mask_interval;
						down_d  = blank_load;
					end else begin
						delay_d = tw'(delay_q - 1'b1);
					end
				end
				default: phase_d = spindle_pkg::phase_off_type_idle;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			phase_q    <= spindle_pkg::phase_off_type_idle;
			down_q     <= '0;
			meas_q     <= '0;
			delay_q    <= '0;
			state_q    <= 3'h0;
			mon_q      <= 1'b1;
			measured_q <= 1'b0;
		end else begin
			phase_q    <= phase_d;
			down_q     <= down_d;
			meas_q     <= meas_d;
			delay_q    <= delay_d;
			state_q    <= state_d;
			mon_q      <= mon_d;
			measured_q <= measured_d;
		end
	end

	// Monitor pin driven from a flop
	logic mon_pin_q, mon_pin_d;
	always_comb begin
		mon_pin_d = blank_q[spindle_pkg::monitor_sel_bit] ? mon_q : sync2_q;
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			mon_pin_q <= 1'b1;
		end else begin
			mon_pin_q <= mon_pin_d;
		end
	end

	// Phase drive table: enable per phase, level high sources, low sinks
	always_comb begin
		phase_high     = 3'b000;
		phase_drive_en = 3'b000;
		if (run) begin
			case (state_q)
				3'h0: begin phase_drive_en = 3'b011; phase_high = 3'b010; end
				3'h1: begin phase_drive_en = 3'b101; phase_high = 3'b100; end
				3'h2: begin phase_drive_en = 3'b110; phase_high = 3'b100; end
				3'h3: begin phase_drive_en = 3'b011; phase_high = 3'b001; end
				3'h4: begin phase_drive_en = 3'b101; phase_high = 3'b001; end
				3'h5: begin phase_drive_en = 3'b110; phase_high = 3'b010; end
				default: begin phase_drive_en = 3'b000; phase_high = 3'b000; end
			endcase
		end
	end

	assign commutation_state       = state_q;
	assign commutation_monitor_pin = mon_pin_q;
	assign centre_tap_bias_en      = ctrl_q[spindle_pkg::bias_bit];
	assign speed_divisor           = {speed_hi_q[11:9], speed_lo_q};
	assign phase_loop_pump_current = speed_hi_q[8:7];
	assign small_dac_route_sel     = speed_hi_q[spindle_pkg::route_bit];
	assign small_dac_to_actuator   = small_dac_route_sel ? speed_hi_q[5:0] : 6'h00;
	assign small_dac_to_spindle    = small_dac_route_sel ? 6'h00 : speed_hi_q[5:0];
	assign actuator_word           = act_q;
	assign actuator_high_gain      = gain_q;
	assign temp_pin_function_sel   = temp_q[spindle_pkg::temp_sel_bit];
	assign shock_threshold         = {shock_q[spindle_pkg::shock_bit], temp_q[9:8]};
	assign temp_sleep_bits         = temp_q;
endmodule

// [spindle_commutation_control_assertions.sv]
// Purpose: Port-level checks for the spindle commutation control block
// Assumes: One clock mclk, synchronous active-high reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module spindle_checker (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [3:0]  reg_index,
	input  wire logic [11:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic [2:0]  phase_high,
	input  wire logic [2:0]  phase_drive_en,
	input  wire logic [2:0]  commutation_state,
	input  wire logic [14:0] speed_divisor,
	input  wire logic [1:0]  phase_loop_pump_current,
	input  wire logic        small_dac_route_sel,
	input  wire logic [5:0]  small_dac_to_actuator,
	input  wire logic [5:0]  small_dac_to_spindle,
	input  wire logic [11:0] actuator_word,
	input  wire logic        actuator_high_gain,
	input  wire logic        temp_pin_function_sel,
	input  wire logic [2:0]  shock_threshold
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire wr0 = reg_write && reg_index == 4'h0;
	wire wr4 = reg_write && reg_index == 4'h4;
	wire wr5 = reg_write && reg_index == 4'h5;
	wire wr6 = reg_write && reg_index == 4'h6;
	wire wr9 = reg_write && reg_index == 4'h9;
	wire wr78 = reg_write && (reg_index == 4'h7 || reg_index == 4'h8);
	chk_speed_high_fields: assert property (wr5 |=> speed_divisor[14:12] == $past(reg_wdata[11:9])
		&& phase_loop_pump_current == $past(reg_wdata[8:7])) else $error("speed high field wrong");
	chk_small_dac_route: assert property (wr5 |=> small_dac_route_sel == $past(reg_wdata[6])
		&& (small_dac_route_sel ? (small_dac_to_actuator == $past(reg_wdata[5:0])
		&& small_dac_to_spindle == 6'h00) : (small_dac_to_spindle == $past(reg_wdata[5:0])
		&& small_dac_to_actuator == 6'h00))) else $error("small dac routing wrong");
	chk_speed_low_word: assert property (wr6 |=> speed_divisor[11:0] == $past(reg_wdata))
		else $error("speed low word wrong");
	chk_actuator_gain_word: assert property (wr78 |=> actuator_word == $past(reg_wdata)
		&& actuator_high_gain == $past(reg_index[3])) else $error("actuator word or gain wrong");
	chk_temp_select_bit: assert property (wr4 |=> temp_pin_function_sel == $past(reg_wdata[0])
		&& shock_threshold[1:0] == $past(reg_wdata[9:8])) else $error("temperature select wrong");
	chk_shock_third_bit: assert property (wr9 |=> shock_threshold[2] == $past(reg_wdata[10]))
		else $error("shock third bit wrong");
	chk_two_phases_driven: assert property (|phase_drive_en |-> $countones(phase_drive_en) == 2
		&& $countones(phase_high & phase_drive_en) == 1 && commutation_state <= 3'h5)
		else $error("drive pattern wrong");
	chk_stop_floats_all: assert property (wr0 && !reg_wdata[5] |-> ##[1:2]
		(phase_drive_en == 3'h0 && commutation_state == 3'h0)) else $error("stop did not float");
	chk_start_state_zero: assert property ($rose(|phase_drive_en) |-> commutation_state == 3'h0)
		else $error("start not from state zero");
	chk_step_one_ahead: assert property (|phase_drive_en && $past(|phase_drive_en)
		&& $changed(commutation_state) |-> commutation_state == ($past(commutation_state) == 3'h5
		? 3'h0 : $past(commutation_state) + 3'h1)) else $error("state skipped");
	cover property (wr5 ##1 small_dac_route_sel);
	cover property (|phase_drive_en && $changed(commutation_state));
	cover property ($fell(|phase_drive_en));
endmodule
bind spindle_commutation_control spindle_checker i_checker (.mclk(mclk), .reset(reset),
	.reg_index(reg_index), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.phase_high(phase_high), .phase_drive_en(phase_drive_en),
	.commutation_state(commutation_state), .speed_divisor(speed_divisor),
	.phase_loop_pump_current(phase_loop_pump_current), .small_dac_route_sel(small_dac_route_sel),
	.small_dac_to_actuator(small_dac_to_actuator), .small_dac_to_spindle(small_dac_to_spindle),
	.actuator_word(actuator_word), .actuator_high_gain(actuator_high_gain),
	.temp_pin_function_sel(temp_pin_function_sel), .shock_threshold(shock_threshold));

// [spindle_motor_model.sv]
// Purpose: Motor and comparator model giving fly-back and back-EMF crossings
// Assumes: Crossing times counted in mclk cycles from each state change
// Notes: When not spinning the comparator holds a level set by the bench
`timescale 1ns/1ps
module spindle_motor_model #(
	parameter int t_flyback = 12,
	parameter int t_second  = 200,
	parameter int t_ring    = 208,
	parameter int t_zero    = 600
) (
	input  wire logic       mclk,
	input  wire logic [2:0] phase_drive_en,
	input  wire logic [2:0] commutation_state,
	input  wire logic       spinning,
	input  wire logic       still_level,
	output logic            comparator
);
	logic [2:0] last_state = 3'h0;
	int         age = 0;
	logic       lvl = 1'b0;
	always @(posedge mclk) begin
		last_state <= commutation_state;
		age <= (commutation_state != last_state || phase_drive_en == 3'h0) ? 0 : age + 1;
		if (spinning && |phase_drive_en && (age == t_flyback || age == t_second
			|| age == t_ring || age == t_zero))
			lvl <= ~lvl;
	end
	assign comparator = spinning ? lvl : still_level;
endmodule

// [spindle_commutation_control_tb.sv]
// Purpose: Self-checking bench for spindle commutation control
// Assumes: Inputs change on falling mclk edges
// Notes: Motor model supplies the comparator crossings
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module spindle_commutation_control_tb;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  reg_index = 4'h0;
	logic [11:0] reg_wdata = 12'h000;
	logic        reg_write = 1'b0;
	logic        spinning = 1'b0;
	logic        still_level = 1'b0;
	logic        comparator, monitor, bias, route, high_gain, temp_sel, mon_mid, mon_early;
	logic [2:0]  phase_high, phase_drive_en, commutation_state, shock, prev;
	logic [14:0] speed;
	logic [1:0]  pump;
	logic [5:0]  dac_act, dac_spin;
	logic [11:0] act_word, temp_bits;
	int          failures = 0;
	int          cmp_count = 0;
	int          n;
	logic [2:0]  en_tab [6] = '{3'h3, 3'h5, 3'h6, 3'h3, 3'h5, 3'h6};
	logic [2:0]  hi_tab [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
	spindle_commutation_control i_dut (.mclk(mclk), .reset(reset), .reg_index(reg_index),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .backemf_comparator_in(comparator),
		.phase_high(phase_high), .phase_drive_en(phase_drive_en),
		.commutation_state(commutation_state), .commutation_monitor_pin(monitor),
		.centre_tap_bias_en(bias), .speed_divisor(speed), .phase_loop_pump_current(pump),
		.small_dac_route_sel(route), .small_dac_to_actuator(dac_act),
		.small_dac_to_spindle(dac_spin), .actuator_word(act_word),
		.actuator_high_gain(high_gain), .temp_pin_function_sel(temp_sel),
		.shock_threshold(shock), .temp_sleep_bits(temp_bits));
	spindle_motor_model i_motor (.mclk(mclk), .phase_drive_en(phase_drive_en),
		.commutation_state(commutation_state), .spinning(spinning),
		.still_level(still_level), .comparator(comparator));
	initial begin
		forever #10 mclk = ~mclk;
	end
	task automatic wr(input logic [3:0] idx, input logic [11:0] val);
		reg_index = idx;
		reg_wdata = val;
		reg_write = 1'b1;
		@(negedge mclk);
		reg_write = 1'b0;
		@(negedge mclk);
	endtask
	task automatic wait_step(output int cnt);
		cnt = 0;
		prev = commutation_state;
		while (commutation_state === prev && cnt < 20000) begin
			@(negedge mclk);
			cnt++;
			if (cnt == 50) mon_early = monitor;
			if (cnt == 1000) mon_mid = monitor;
		end
	endtask
	task automatic summarize;
		if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#(20 * 80000);
		failures++;
		summarize;
	end
	initial begin
		repeat (8) @(negedge mclk);
		reset = 1'b0;
		`CHK("reset_out", {12'h07c, 3'h0, 1'b1}, {temp_bits, phase_drive_en, monitor})
		wr(4'h5, 12'had5);
		`CHK("reg5", {3'h5, 2'h1, 6'h15, 6'h00}, {speed[14:12], pump, dac_act, dac_spin})
		wr(4'h5, 12'h02a);
		`CHK("route", {1'b0, 6'h2a, 6'h00}, {route, dac_spin, dac_act})
		wr(4'h6, 12'h123);
		`CHK("speed", 15'h0123, speed)
		wr(4'h7, 12'h7ff);
		`CHK("gain_lo", {1'b0, 12'h7ff}, {high_gain, act_word})
		wr(4'h8, 12'h800);
		`CHK("gain_hi", {1'b1, 12'h800}, {high_gain, act_word})
		wr(4'h4, 12'h301);
		wr(4'h9, 12'h400);
		`CHK("temp_shock", {1'b1, 3'h7}, {temp_sel, shock})
		wr(4'h3, 12'hfff);
		wr(4'ha, 12'hfff);
		`CHK("refused", {12'h301, 12'h800, 15'h0123}, {temp_bits, act_word, speed})
		wr(4'h4, 12'h07c);
		`CHK("temp_sel", 1'b0, temp_sel)
		wr(4'h0, 12'h040);
		`CHK("bias", 1'b1, bias)
		wr(4'h2, 12'h000);
		still_level = 1'b1;
		repeat (40) @(negedge mclk);
		`CHK("mon_cmp_hi", 1'b1, monitor)
		still_level = 1'b0;
		repeat (40) @(negedge mclk);
		`CHK("mon_cmp_lo", 1'b0, monitor)
		wr(4'h2, 12'h080);
		wr(4'h1, 12'h000);
		for (int code = 0; code < 4; code++) begin
			wr(4'h0, 12'h000);
			`CHK("stop", 6'h00, {phase_drive_en, commutation_state})
			wr(4'h0, {3'h0, 2'(code), 7'h20});
			wait_step(n);
			`CHK("wd_early", 1'b1, n > 515 * (4 << code))
			`CHK("wd_late", 1'b1, n < 526 * (4 << code))
			`CHK("wd_state", 3'h1, commutation_state)
		end
		wr(4'h0, 12'h000);
		spinning = 1'b1;
		wr(4'h0, 12'h020);
		`CHK("start", 9'h01a, {commutation_state, phase_drive_en, phase_high & phase_drive_en})
		for (int k = 1; k <= 7; k++) begin
			wait_step(n);
			`CHK("zc_step", 1'b1, n > 1050 && n < 1250)
			`CHK("mon_edges", 2'h2, {mon_early, mon_mid})
			`CHK("state_seq", 3'(k % 6), commutation_state)
			`CHK("phases", {en_tab[k % 6], hi_tab[k % 6]}, {phase_drive_en, phase_high & phase_drive_en})
		end
		wr(4'h0, 12'h000);
		`CHK("stop_end", 6'h00, {phase_drive_en, commutation_state})
		summarize;
	end
endmodule
